// [rtl/tcpcm_timer.sv]
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "tcpcm_defines.svh"

module tcpcm_timer (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // timer pins
    input  wire logic        timer_in,
    output logic             timer_out,
    output logic             timer_event
);
    // ==========================================
    // reset release
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ==========================================
    // registers and decode
    logic [7:0]  ctrl_q;
    logic [15:0] count_q;
    logic [15:0] reload_q;
    logic [7:0]  reload_hold_q;
    logic [15:0] mcap_q;
    logic [7:0]  low_hold_q;
    logic [2:0]  sticky_q;
    logic        out_q;

    tcpcm_pkg::tcpcm_mode_type mode;
    logic enabled;
    logic pol;
    logic oe;
    logic req;
    logic wr;
    logic rd;
    logic lane0;

    assign mode    = tcpcm_pkg::tcpcm_mode_type'(ctrl_q[`TCPCM_CTRL_MODE_HI:`TCPCM_CTRL_MODE_LO]);
    assign enabled = ctrl_q[`TCPCM_CTRL_EN];
    assign pol     = ctrl_q[`TCPCM_CTRL_POL];
    assign oe      = ctrl_q[`TCPCM_CTRL_OE];
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign lane0   = wb_sel_i[0];
    assign wr      = req && wb_we_i && lane0;
    assign rd      = req && !wb_we_i;

    // ==========================================
    // input synchroniser and edge detect
    logic in_s1_q;
    logic in_s2_q;
    logic in_s3_q;
    logic edge_hit;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
            in_s3_q <= 1'b0;
        end else begin
            in_s1_q <= timer_in;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end

    // rising when pol is 1, falling when pol is 0
    assign edge_hit = pol ? (in_s2_q && !in_s3_q)
                          : (!in_s2_q && in_s3_q);

    // ==========================================
    // count step
    logic tick;
    logic step;

    tcpcm_prescaler #(
        .WIDTH(7)
    ) tcpcm_prescaler_inst (
        .clk_sys(clk_sys),
        .rst_n  (rst_n_q),
        .run    (enabled && mode != tcpcm_pkg::TCPCM_COUNTER),
        .sel    (ctrl_q[`TCPCM_CTRL_PRE_HI:`TCPCM_CTRL_PRE_LO]),
        .tick   (tick)
    );

    // counter mode ignores the prescaler entirely
    assign step = enabled && ((mode == tcpcm_pkg::TCPCM_COUNTER) ? edge_hit : tick);

    logic at_reload;
    logic at_match;
    logic do_restart;
    logic capture;

    assign at_reload  = step && (count_q == reload_q);
    assign at_match   = step && (count_q == mcap_q);
    assign do_restart = at_reload && (mode == tcpcm_pkg::TCPCM_COUNTER
                                      || mode == tcpcm_pkg::TCPCM_PWM);
    assign capture    = enabled && (mode == tcpcm_pkg::TCPCM_CAPTURE) && edge_hit;

    // ==========================================
    // counter
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_q <= `TCPCM_RST_CNT;
        end else if (wr && wb_adr_i == `TCPCM_ADDR_CNTH) begin
            count_q[15:8] <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == `TCPCM_ADDR_CNTL) begin
            count_q[7:0] <= wb_dat_i[7:0];
        end else if (do_restart) begin
            // in counter and PWM modes later passes start at one, not the written value
            count_q <= `TCPCM_RESTART;
        end else if (step) begin
            // plain increment also wraps ffff to 0000 and
            count_q <= count_q + 16'h0001;
        end
    end

    // ==========================================
    // reload with high byte staging
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reload_q      <= `TCPCM_RST_RLD;
            reload_hold_q <= 8'(`TCPCM_RST_RLD >> 8);
        end else if (wr && wb_adr_i == `TCPCM_ADDR_RLDH) begin
            reload_hold_q <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == `TCPCM_ADDR_RLDL) begin
            reload_q <= {reload_hold_q, wb_dat_i[7:0]};
        end
    end

    // ==========================================
    // match / capture register
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mcap_q <= `TCPCM_RST_MCAP;
        end else if (capture) begin
            mcap_q <= count_q;
        end else if (wr && wb_adr_i == `TCPCM_ADDR_MCAPH) begin
            mcap_q[15:8] <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == `TCPCM_ADDR_MCAPL) begin
            mcap_q[7:0] <= wb_dat_i[7:0];
        end
    end

    // ==========================================
    // control register
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= `TCPCM_RST_CTRL;
        end else if (wr && wb_adr_i == `TCPCM_ADDR_CTRL) begin
            ctrl_q <= wb_dat_i[7:0];
        end
    end

    // ==========================================
    // timer output
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_q <= 1'b0;
        end else if (!enabled) begin
            // idle level follows polarity while stopped, output enable or not
            out_q <= pol;
        end else begin
            unique case (mode)
                tcpcm_pkg::TCPCM_COUNTER: begin
                    if (at_reload && oe) out_q <= !out_q;
                end
                tcpcm_pkg::TCPCM_PWM: begin
                    if (at_reload) out_q <= pol;
                    else if (at_match) out_q <= !pol;
                end
                tcpcm_pkg::TCPCM_CAPTURE: begin
                    out_q <= out_q;
                end
                tcpcm_pkg::TCPCM_COMPARE: begin
                    if (at_reload && oe) out_q <= !out_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= out_q;
        end
    end

    // ==========================================
    // event pulse and sticky cause bits
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_event <= 1'b0;
        end else begin
            timer_event <= at_reload || capture;
        end
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sticky_q <= 3'h0;
        end else begin
            sticky_q <= (sticky_q & ~((wr && wb_adr_i == `TCPCM_ADDR_STATUS)
                                      ? wb_dat_i[2:0] : 3'h0))
                        | {at_reload && mode == tcpcm_pkg::TCPCM_COMPARE,
                           capture,
                           at_reload && mode != tcpcm_pkg::TCPCM_COMPARE};
        end
    end

    // ==========================================
    // bus read path and coherent low-byte hold
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            low_hold_q <= 8'h00;
        end else if (rd && enabled && wb_adr_i == `TCPCM_ADDR_CNTH) begin
            low_hold_q <= count_q[7:0];
        end
    end

    logic [7:0] rd_byte;

    always_comb begin
        unique case (wb_adr_i)
            `TCPCM_ADDR_CTRL:   rd_byte = ctrl_q;
            `TCPCM_ADDR_CNTH:   rd_byte = count_q[15:8];
            `TCPCM_ADDR_CNTL:   rd_byte = enabled ? low_hold_q : count_q[7:0];
            `TCPCM_ADDR_RLDH:   rd_byte = reload_q[15:8];
            `TCPCM_ADDR_RLDL:   rd_byte = reload_q[7:0];
            `TCPCM_ADDR_MCAPH:  rd_byte = mcap_q[15:8];
            `TCPCM_ADDR_MCAPL:  rd_byte = mcap_q[7:0];
            `TCPCM_ADDR_STATUS: rd_byte = {4'h0, out_q, sticky_q};
            default:            rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end
endmodule

// [inc/tcpcm_defines.svh]
`ifndef TCPCM_DEFINES_SVH
`define TCPCM_DEFINES_SVH

// register byte addresses
`define TCPCM_ADDR_CTRL    8'h00
`define TCPCM_ADDR_CNTH    8'h04
`define TCPCM_ADDR_CNTL    8'h08
`define TCPCM_ADDR_RLDH    8'h0c
`define TCPCM_ADDR_RLDL    8'h10
`define TCPCM_ADDR_MCAPH   8'h14
`define TCPCM_ADDR_MCAPL   8'h18
`define TCPCM_ADDR_STATUS  8'h1c

// control register fields
`define TCPCM_CTRL_EN      7
`define TCPCM_CTRL_POL     6
`define TCPCM_CTRL_PRE_HI  5
`define TCPCM_CTRL_PRE_LO  3
`define TCPCM_CTRL_OE      2
`define TCPCM_CTRL_MODE_HI 1
`define TCPCM_CTRL_MODE_LO 0

// status register fields
`define TCPCM_STAT_RLD     0
`define TCPCM_STAT_CAP     1
`define TCPCM_STAT_CMP     2
`define TCPCM_STAT_OUT     3

// reset values
`define TCPCM_RST_CTRL     8'h00
`define TCPCM_RST_CNT      16'h0000
`define TCPCM_RST_RLD      16'hffff
`define TCPCM_RST_MCAP     16'h0000
`define TCPCM_RESTART      16'h0001
`define TCPCM_WRAP         16'h0000

`endif

// [inc/tcpcm_pkg.sv]
package tcpcm_pkg;

    typedef enum logic [1:0] {
        TCPCM_COUNTER,
        TCPCM_PWM,
        TCPCM_CAPTURE,
        TCPCM_COMPARE
    } tcpcm_mode_type;

endpackage

// [rtl/tcpcm_prescaler.sv]
`timescale 1ns/1ns
`include "tcpcm_defines.svh"

module tcpcm_prescaler #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // control
    input  wire logic             run,
    input  wire logic [2:0]       sel,
    // enable out
    output logic                  tick
);
    // ==========================================
    // divide by 2**sel, 1 to 128
    // the select field is three bits wide, so only a seven-bit divider fits it
    if (WIDTH != 7) begin : g_width_check
        $error("prescaler width must be 7");
    end

    logic [WIDTH-1:0] div_q;
    logic [WIDTH-1:0] mask;

    assign mask = WIDTH'((8'h01 << sel) - 8'h01);
    assign tick = run && ((div_q & mask) == mask);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (!run) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + WIDTH'(1);
        end
    end
endmodule

// [dv/tcpcm_timer_properties.sv]
`timescale 1ns/1ns
// ====
// port checker
module tcpcm_timer_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic        timer_in,
    input wire logic        timer_out,
    input wire logic        timer_event
);
    logic [7:0] ctrl_q;
    // shadow lags the real register by one edge, so the idle-level, off-quiet and output-hold checks wait three
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= 8'h00;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00) begin
            ctrl_q <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack unasked");
    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper data");
    a_idle_level: assert property (
        (!ctrl_q[7] && $stable(ctrl_q))[*3] |-> timer_out == ctrl_q[6])
        else $error("idle level");
    a_off_quiet: assert property ((!ctrl_q[7])[*3] |-> !timer_event)
        else $error("event while off");
    a_oe_hold: assert property (
        (ctrl_q[7] && !ctrl_q[2] && ctrl_q[0] == ctrl_q[1] && $stable(ctrl_q))[*3]
        |-> $stable(timer_out))
        else $error("output moved");
    a_cap_event: assert property (
        ctrl_q == 8'hc2 && $rose(timer_in) |-> ##[2:6] timer_event)
        else $error("no capture event");
endmodule

bind tcpcm_timer tcpcm_timer_checker tcpcm_timer_checker_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_in(timer_in), .timer_out(timer_out),
    .timer_event(timer_event));

// [dv/tcpcm_pin_model.sv]
`timescale 1ns/1ns
// ====
// input pin source
module tcpcm_pin_model (
    // clock
    input wire logic clk_sys,
    // pin
    output logic     timer_in
);
    initial timer_in = 1'b0;
    // each level lasts two clocks or more, a quarter of the clock at most
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge clk_sys) timer_in <= 1'b1;
            repeat (2) @(posedge clk_sys);
            timer_in <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
endmodule

// [dv/timer_count_pwm_capture_modes_tb_top.sv]
`timescale 1ns/1ns
// ====
// bench
module timer_count_pwm_capture_modes_tb_top;
    logic        clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        timer_in, timer_out, timer_event;
    logic [7:0]  wb_adr_i, q;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] v, w;
    int          fail_count = 0, compares = 0, ev = 0, ev0, div, hi;
    typedef struct { logic [7:0] a; logic [7:0] e; } tcpcm_row_type;
    tcpcm_row_type rows [10] = '{'{8'h00, 8'h00}, '{8'h04, 8'h00}, '{8'h08, 8'h00},
        '{8'h0c, 8'hff}, '{8'h10, 8'hff}, '{8'h14, 8'h00}, '{8'h18, 8'h00},
        '{8'h1c, 8'h00}, '{8'h20, 8'h00}, '{8'h02, 8'h00}};

    tcpcm_timer tcpcm_timer_inst (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .timer_in(timer_in), .timer_out(timer_out), .timer_event(timer_event));
    tcpcm_pin_model tcpcm_pin_model_inst (.clk_sys(clk_sys), .timer_in(timer_in));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (timer_event === 1'b1) ev <= ev + 1;

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask
    // the answer is read at the ack edge itself, before that edge's updates land
    task automatic wb(input logic wr, input logic [7:0] a, d, input logic [3:0] s,
                      output logic [7:0] r);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, wr, a, s};
        wb_dat_i <= {24'h000000, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        r = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] r;
        wb(1'b1, a, d, 4'h1, r);
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[15:8]);
        wr(a + 8'h04, d[7:0]);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] r);
        wb(1'b0, a, 8'h00, 4'h1, r[15:8]);
        wb(1'b0, a + 8'h04, 8'h00, 4'h1, r[7:0]);
    endtask
    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end

    initial begin
        {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        foreach (rows[i]) begin
            wb(1'b0, rows[i].a, 8'h00, 4'h1, q);
            chk("reset", {8'h00, q}, {8'h00, rows[i].e});
        end
        wb(1'b1, 8'h00, 8'hc0, 4'h2, q);
        wb(1'b0, 8'h00, 8'h00, 4'h1, q);
        chk("sel", {8'h00, q}, 16'h0000);
        wr(8'h00, 8'h80);
        repeat (6) @(posedge clk_sys);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h78);
        repeat (4) @(posedge clk_sys);
        chk("idle", {15'h0, timer_out}, 16'h1);
        wr16(8'h04, 16'h0003); // start off one on purpose
        wr16(8'h0c, 16'h0005);
        wr(8'h00, 8'hfc);
        tcpcm_pin_model_inst.edges(2);
        rd16(8'h04, v);
        chk("cnt", v, 16'h0005);
        tcpcm_pin_model_inst.edges(1);
        rd16(8'h04, v);
        chk("cnt", v, 16'h0001);
        chk("ev", ev[15:0], 16'h1);
        chk("out", {15'h0, timer_out}, 16'h0);
        tcpcm_pin_model_inst.edges(4);
        wb(1'b0, 8'h04, 8'h00, 4'h1, v[15:8]);
        tcpcm_pin_model_inst.edges(1);
        wb(1'b0, 8'h08, 8'h00, 4'h1, v[7:0]);
        chk("latch", v, 16'h0005);
        chk("ev", ev[15:0], 16'h2);
        for (int i = 0; i < 2; i++) begin
            div = i ? 128 : 1;
            wr(8'h00, 8'h00);
            wr(8'h00, i ? 8'h39 : 8'h41);
            wr16(8'h04, 16'h0001);
            wr16(8'h14, 16'h0002);
            wr16(8'h0c, 16'h0006);
            wr(8'h00, i ? 8'hb9 : 8'hc1);
            repeat (6 * div) @(posedge clk_sys);
            ev0 = ev;
            hi = 0;
            repeat (12 * div) begin
                @(posedge clk_sys);
                if (timer_out === 1'b1) hi++;
            end
            chk("pwm high", hi[15:0], 16'(i ? 8 * div : 4 * div));
            chk("pwm ev", 16'(ev - ev0), 16'h2);
        end
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h42);
        wr16(8'h14, 16'h0000);
        wr16(8'h04, 16'h0001);
        // reload sits just past the capture, so both events land in this scenario
        wr16(8'h0c, 16'h0020);
        wr(8'h00, 8'hc2);
        ev0 = ev;
        repeat (20) @(posedge clk_sys);
        tcpcm_pin_model_inst.edges(1);
        // event counter lags the pulse by one edge, so read the registers first
        rd16(8'h14, v);
        rd16(8'h04, w);
        chk("cap ev", 16'(ev - ev0), 16'h2);
        chk("cap", {15'h0, v > 16'h0010 && v < 16'h0030 && w > v}, 16'h1);
        chk("cap run", {15'h0, w > 16'h0020}, 16'h1);
        wb(1'b0, 8'h1c, 8'h00, 4'h1, q);
        chk("status", {8'h00, q}, 16'h000b);
        wr(8'h1c, 8'h07);
        wb(1'b0, 8'h1c, 8'h00, 4'h1, q);
        chk("clear", {8'h00, q}, 16'h0008);
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h47);
        wr16(8'h04, 16'hfff0);
        wr16(8'h0c, 16'hfff8);
        wr(8'h00, 8'hc7);
        ev0 = ev;
        repeat (40) @(posedge clk_sys);
        chk("cmp ev", 16'(ev - ev0), 16'h1);
        chk("cmp out", {15'h0, timer_out}, 16'h0);
        rd16(8'h04, v);
        chk("wrap", {15'h0, v > 16'h0010 && v < 16'h0040}, 16'h1);
        wr(8'h00, 8'h47);
        rd16(8'h04, v);
        repeat (20) @(posedge clk_sys);
        rd16(8'h04, w);
        chk("hold", w, v);
        // compare with the output function off: event still comes, pin keeps idle level
        wr(8'h00, 8'h43);
        wr16(8'h04, 16'hfff6);
        wr16(8'h0c, 16'hfff8);
        wr(8'h00, 8'hc3);
        ev0 = ev;
        repeat (20) @(posedge clk_sys);
        chk("cmp ev", 16'(ev - ev0), 16'h1);
        chk("oe off", {15'h0, timer_out}, 16'h1);
        end_sim();
    end
endmodule
